// ---- rpx_map.vh ----
// register offsets, field layout, reset values and timing counts of the point exchange
`ifndef RPX_MAP_VH
`define RPX_MAP_VH

// -----------------------------------------------------------------
// timing
// -----------------------------------------------------------------
`define RPX_CLK_NS       25
`define RPX_MS_NS        1000000
`define RPX_HOLD_MULT    18'd3

// -----------------------------------------------------------------
// sizes
// -----------------------------------------------------------------
`define RPX_N_ORIG       16
`define RPX_N_RIN        32
`define RPX_N_ROUT       64
`define RPX_N_FIELDS     128
`define RPX_PAYLOAD_W    256
`define RPX_KEPT_W       128
`define RPX_HOLD_W       18

// -----------------------------------------------------------------
// register byte offsets (8-bit address space)
// -----------------------------------------------------------------
`define RPX_INTERVAL_OFS 8'h00
`define RPX_LOCAL_ID_OFS 8'h04
`define RPX_ORIG_EN_OFS  8'h08
`define RPX_ONLINE_OFS   8'h0c
`define RPX_IRQ_STAT_OFS 8'h10
`define RPX_IRQ_MASK_OFS 8'h14
`define RPX_RIN_OFS      8'h18
`define RPX_ID_REGION    2'b01
`define RPX_CFG_REGION   1'b1

// -----------------------------------------------------------------
// reset values
// -----------------------------------------------------------------
`define RPX_INTERVAL_RST 16'h03e8
`define RPX_LOCAL_ID_RST 32'h0000_5a01

// -----------------------------------------------------------------
// remote input configuration fields
// -----------------------------------------------------------------
`define RPX_CFG_ORIG_LSB 0
`define RPX_CFG_SEL_LSB  8
`define RPX_CFG_MODE_LSB 16
`define RPX_MODE_ON      2'h0
`define RPX_MODE_OFF     2'h1
`define RPX_MODE_LAT_ON  2'h2
`define RPX_MODE_LAT_OFF 2'h3

// -----------------------------------------------------------------
// interrupt status bits, point encodings, bus answers
// -----------------------------------------------------------------
`define RPX_EV_TX        0
`define RPX_EV_RX        1
`define RPX_EV_LOST      2
`define RPX_PT_ON        2'h2
`define RPX_PT_OFF       2'h1
`define RPX_RESP_OKAY    2'h0
`define RPX_RESP_SLVERR  2'h2

`endif

// ---- rpx_id_mem.v ----
// originator identity table: one write port, one registered read port
module rpx_id_mem #(
    parameter AW = 4,
    parameter DW = 32
) (
    // clock
    input  wire          clk,
    // write side
    input  wire          we,
    input  wire [AW-1:0] waddr,
    input  wire [DW-1:0] wdata,
    // read side, data one cycle after the address
    input  wire [AW-1:0] raddr,
    output reg  [DW-1:0] rdata
);

    // storage, no reset: software loads it before enabling originators
    reg [DW-1:0] mem [0:(1<<AW)-1];

    // -----------------------------------------------------------------
    // write and registered read
    // -----------------------------------------------------------------
    always @(posedge clk)
    begin
        if (we)
        begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end

endmodule

// ---- rpx_exchange.v ----
// remote point state exchange: message send, per-originator hold timers, remote inputs
//
// Function
// - send at power-up, on change, on interval
// - sent hold time is three times interval
// - accept points only from selected originators
// - payload reserves 128 two-bit point fields
// - 32 predefined plus 32 user fields used
// - load originator hold timer from message
// - expired timer: offline, use default states
// - message before expiry updates points, restarts
// - per-originator online status is readable
// - 32 remote inputs, 64 remote outputs
// - sixteen originators, each with programmed identity
// - input picks originator number and field
// - fixed defaults at startup or while offline
// - latest modes freeze last value, else default
`include "rpx_map.vh"
module rpx_exchange #(
    parameter CYC_PER_MS = `RPX_MS_NS / `RPX_CLK_NS,
    parameter ID_W       = 32
) (
    // clock and reset
    input  wire                      aclk,
    input  wire                      aresetn,
    // axi4-lite write
    input  wire [7:0]                awaddr,
    input  wire                      awvalid,
    output wire                      awready,
    input  wire [31:0]               wdata,
    input  wire [3:0]                wstrb,
    input  wire                      wvalid,
    output wire                      wready,
    output reg  [1:0]                bresp,
    output reg                       bvalid,
    input  wire                      bready,
    // axi4-lite read
    input  wire [7:0]                araddr,
    input  wire                      arvalid,
    output wire                      arready,
    output reg  [31:0]               rdata,
    output reg  [1:0]                rresp,
    output reg                       rvalid,
    input  wire                      rready,
    // interrupt
    output wire                      irq,
    // received messages from the network side
    input  wire                      rx_valid,
    output wire                      rx_ready,
    input  wire [ID_W-1:0]           rx_ident,
    input  wire [`RPX_HOLD_W-1:0]    rx_hold,
    input  wire [`RPX_PAYLOAD_W-1:0] rx_fields,
    // messages to transmit
    output reg                       tx_valid,
    input  wire                      tx_ready,
    output reg  [ID_W-1:0]           tx_ident,
    output reg  [`RPX_HOLD_W-1:0]    tx_hold,
    output reg  [`RPX_PAYLOAD_W-1:0] tx_fields,
    // local logic points and remote results
    input  wire [`RPX_N_ROUT-1:0]    tx_points,
    output reg  [`RPX_N_RIN-1:0]     rin_state,
    output reg  [`RPX_N_ORIG-1:0]    orig_online
);

    // scan states
    localparam S_IDLE = 2'h0;
    localparam S_RD   = 2'h1;
    localparam S_CMP  = 2'h2;

    // -----------------------------------------------------------------
    // software registers
    // -----------------------------------------------------------------
    reg  [15:0]                interval;  // default update interval, ms
    reg  [ID_W-1:0]            local_id;  // identity sent in every message
    reg  [`RPX_N_ORIG-1:0]     orig_en;   // originator selected
    reg  [2:0]                 irq_stat;  // sticky events
    reg  [2:0]                 irq_mask;  // event enables
    wire [`RPX_N_RIN*18-1:0]   cfg_flat;  // all remote input settings

    // bus write holding
    reg                        aw_full;
    reg                        w_full;
    reg  [7:0]                 aw_q;
    reg  [31:0]                wd_q;
    reg  [3:0]                 ws_q;

    // ms tick
    reg  [31:0]                pcnt;
    wire                       ms_tick = (pcnt == CYC_PER_MS - 1);

    // receive scan
    reg  [1:0]                 state;
    reg  [3:0]                 idx;
    reg  [ID_W-1:0]            ident_q;
    reg  [`RPX_HOLD_W-1:0]     hold_q;
    reg  [`RPX_KEPT_W-1:0]     fields_q;
    wire [ID_W-1:0]            id_rdata;
    wire [`RPX_N_ORIG-1:0]     lost;

    // transmit
    reg  [15:0]                int_cnt;
    reg                        tx_pend;
    reg  [`RPX_N_ROUT-1:0]     pts_prev;
    wire [`RPX_PAYLOAD_W-1:0]  fields_nx;

    // -----------------------------------------------------------------
    // write channel: address and data taken in either order
    // -----------------------------------------------------------------
    assign awready = !aw_full;
    assign wready  = !w_full;
    wire   wr_go   = aw_full & w_full & !bvalid;

    // byte lanes of the held write
    wire [31:0] bm = {{8{ws_q[3]}}, {8{ws_q[2]}}, {8{ws_q[1]}}, {8{ws_q[0]}}};

    // merge strobed bytes over the old value
    function [31:0] mrg;
        input [31:0] old;
        begin
            mrg = (old & ~bm) | (wd_q & bm);
        end
    endfunction

    // offset decode, shared by both channels
    function mapped;
        input [7:0] a;
        begin
            mapped = (a[1:0] == 2'h0) && (a[7] || a[6] || (a[5:2] <= 4'h6));
        end
    endfunction

    wire wr_id  = wr_go && (aw_q[7:6] == `RPX_ID_REGION) && (aw_q[1:0] == 2'h0);
    wire wr_cfg = wr_go && (aw_q[7] == `RPX_CFG_REGION) && (aw_q[1:0] == 2'h0);

    wire [31:0] m_int  = mrg({16'h0000, interval});
    wire [31:0] m_lid  = mrg(local_id);
    wire [31:0] m_en   = mrg({16'h0000, orig_en});
    wire [31:0] m_msk  = mrg({29'h0, irq_mask});
    wire [2:0]  clr    = (wr_go && aw_q == `RPX_IRQ_STAT_OFS) ? (wd_q[2:0] & bm[2:0]) : 3'h0;
    wire [2:0]  ev_set;

    // write handshake and response
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_full <= 1'b0;
            w_full  <= 1'b0;
            aw_q    <= 8'h00;
            wd_q    <= 32'h0;
            ws_q    <= 4'h0;
            bvalid  <= 1'b0;
            bresp   <= `RPX_RESP_OKAY;
        end
        else
        begin
            if (awvalid && !aw_full)
            begin
                aw_full <= 1'b1;
                aw_q    <= awaddr;
            end
            else if (wr_go)
            begin
                aw_full <= 1'b0;
            end
            if (wvalid && !w_full)
            begin
                w_full <= 1'b1;
                wd_q   <= wdata;
                ws_q   <= wstrb;
            end
            else if (wr_go)
            begin
                w_full <= 1'b0;
            end
            if (wr_go)
            begin
                // unmapped offsets answer slverr and change nothing
                bvalid <= 1'b1;
                bresp  <= mapped(aw_q) ? `RPX_RESP_OKAY : `RPX_RESP_SLVERR;
            end
            else if (bready)
            begin
                bvalid <= 1'b0;
            end
        end
    end

    // plain registers and sticky status
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            interval <= `RPX_INTERVAL_RST;
            local_id <= `RPX_LOCAL_ID_RST;
            orig_en  <= 16'h0000;
            irq_mask <= 3'h0;
            irq_stat <= 3'h0;
        end
        else
        begin
            if (wr_go)
            begin
                case (aw_q)
                    `RPX_INTERVAL_OFS: interval <= m_int[15:0];
                    `RPX_LOCAL_ID_OFS: local_id <= m_lid[ID_W-1:0];
                    `RPX_ORIG_EN_OFS:  orig_en  <= m_en[15:0];
                    `RPX_IRQ_MASK_OFS: irq_mask <= m_msk[2:0];
                    default:           irq_mask <= irq_mask;
                endcase
            end
            // a new event wins over a clear in the same cycle
            irq_stat <= (irq_stat & ~clr) | ev_set;
        end
    end

    assign irq = |(irq_stat & irq_mask);

    // -----------------------------------------------------------------
    // read channel: one answer at a time, data registered
    // -----------------------------------------------------------------
    assign arready = !rvalid;

    reg [31:0] rd_val;
    // identities are write-only: the table's read port belongs to the scan
    always @*
    begin
        rd_val = 32'h0;
        if (araddr[7] == `RPX_CFG_REGION)
        begin
            rd_val = {14'h0000, cfg_flat[araddr[6:2]*18 +: 18]};
        end
        else
        begin
            case (araddr)
                `RPX_INTERVAL_OFS: rd_val = {16'h0000, interval};
                `RPX_LOCAL_ID_OFS: rd_val = local_id;
                `RPX_ORIG_EN_OFS:  rd_val = {16'h0000, orig_en};
                `RPX_ONLINE_OFS:   rd_val = {16'h0000, orig_online};
                `RPX_IRQ_STAT_OFS: rd_val = {29'h0, irq_stat};
                `RPX_IRQ_MASK_OFS: rd_val = {29'h0, irq_mask};
                `RPX_RIN_OFS:      rd_val = rin_state;
                default:           rd_val = 32'h0;
            endcase
        end
    end

    // read handshake
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid <= 1'b0;
            rdata  <= 32'h0;
            rresp  <= `RPX_RESP_OKAY;
        end
        else if (arvalid && !rvalid)
        begin
            rvalid <= 1'b1;
            rdata  <= rd_val;
            rresp  <= mapped(araddr) ? `RPX_RESP_OKAY : `RPX_RESP_SLVERR;
        end
        else if (rready)
        begin
            rvalid <= 1'b0;
        end
    end

    // -----------------------------------------------------------------
    // millisecond tick for hold timers and update interval
    // -----------------------------------------------------------------
    always @(posedge aclk)
    begin
        if (!aresetn || ms_tick)
        begin
            pcnt <= 32'h0;
        end
        else
        begin
            pcnt <= pcnt + 32'h1;
        end
    end

    // -----------------------------------------------------------------
    // receive: walk the identity table once per message
    // -----------------------------------------------------------------
    assign rx_ready = (state == S_IDLE);

    // identity table, one entry per originator number minus one
    rpx_id_mem #(
        .AW (4),
        .DW (ID_W)
    ) u_ids (
        .clk   (aclk),
        .we    (wr_id),
        .waddr (aw_q[5:2]),
        .wdata (wd_q[ID_W-1:0]),
        .raddr (idx),
        .rdata (id_rdata)
    );

    // only enabled originators whose identity matches are taken
    wire cmp_hit = (state == S_CMP) && orig_en[idx] && (id_rdata == ident_q);

    // scan sequencer: 2 cycles per table entry
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state    <= S_IDLE;
            idx      <= 4'h0;
            ident_q  <= {ID_W{1'b0}};
            hold_q   <= {`RPX_HOLD_W{1'b0}};
            fields_q <= {`RPX_KEPT_W{1'b0}};
        end
        else
        begin
            case (state)
                S_IDLE:
                begin
                    if (rx_valid)
                    begin
                        // every message is examined; only fields 0..63 are kept
                        ident_q  <= rx_ident;
                        hold_q   <= rx_hold;
                        fields_q <= rx_fields[`RPX_KEPT_W-1:0];
                        idx      <= 4'h0;
                        state    <= S_RD;
                    end
                end
                S_RD:
                begin
                    state <= S_CMP;
                end
                S_CMP:
                begin
                    if (idx == 4'hf)
                    begin
                        state <= S_IDLE;
                    end
                    else
                    begin
                        idx   <= idx + 4'h1;
                        state <= S_RD;
                    end
                end
                default:
                begin
                    state <= S_IDLE;
                end
            endcase
        end
    end

    // -----------------------------------------------------------------
    // hold timers, one per originator
    // -----------------------------------------------------------------
    genvar k;
    generate
        for (k = 0; k < `RPX_N_ORIG; k = k + 1)
        begin : g_orig
            reg  [`RPX_HOLD_W-1:0] tmr;
            wire hit = cmp_hit && (idx == k);
            assign lost[k] = ms_tick && (tmr == 18'h1) && !hit;
            always @(posedge aclk)
            begin
                if (!aresetn)
                begin
                    // expired from reset so inputs show defaults
                    tmr            <= 18'h0;
                    orig_online[k] <= 1'b0;
                end
                else if (hit)
                begin
                    // restart with the message's hold time
                    tmr            <= hold_q;
                    orig_online[k] <= |hold_q;
                end
                else if (ms_tick && tmr != 18'h0)
                begin
                    // timeout declares the originator offline
                    tmr            <= tmr - 18'h1;
                    orig_online[k] <= (tmr != 18'h1);
                end
            end
        end
    endgenerate

    assign ev_set = {|lost, cmp_hit, tx_valid & tx_ready};

    // -----------------------------------------------------------------
    // remote inputs
    // -----------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < `RPX_N_RIN; i = i + 1)
        begin : g_rin
            reg  [17:0] cfg;   // mode, field select, originator number
            reg         last;  // latest received state
            reg         have;  // a state has been received since reset
            wire [31:0] m_cfg = mrg({14'h0000, cfg});
            wire [4:0]  onum  = cfg[`RPX_CFG_ORIG_LSB +: 5];
            wire [5:0]  sel   = cfg[`RPX_CFG_SEL_LSB +: 6];
            wire [1:0]  mode  = cfg[`RPX_CFG_MODE_LSB +: 2];
            wire [3:0]  oi    = onum[3:0] - 4'h1;
            wire        ok    = (onum != 5'h0) && (onum <= 5'h10);
            wire        live  = ok && orig_online[oi];
            reg         nx;
            assign cfg_flat[i*18 +: 18] = cfg;

            // pick the value to present
            always @*
            begin
                nx = 1'b0;
                if (live && have)
                begin
                    nx = last;
                end
                else
                begin
                    case (mode)
                        `RPX_MODE_ON:      nx = 1'b1;
                        `RPX_MODE_OFF:     nx = 1'b0;
                        `RPX_MODE_LAT_ON:  nx = have ? last : 1'b1;
                        `RPX_MODE_LAT_OFF: nx = have & last;
                        default:           nx = 1'b0;
                    endcase
                end
            end

            always @(posedge aclk)
            begin
                if (!aresetn)
                begin
                    cfg          <= 18'h0;
                    last         <= 1'b0;
                    have         <= 1'b0;
                    rin_state[i] <= 1'b0;
                end
                else
                begin
                    if (wr_cfg && aw_q[6:2] == i)
                    begin
                        cfg <= m_cfg[17:0];
                    end
                    if (cmp_hit && ok && idx == oi)
                    begin
                        // the state is the high bit of the chosen pair
                        last <= fields_q[{sel, 1'b1}];
                        have <= 1'b1;
                    end
                    rin_state[i] <= nx;
                end
            end
        end
    endgenerate

    // -----------------------------------------------------------------
    // transmit: 64 local points into the first 64 fields
    // -----------------------------------------------------------------
    genvar j;
    generate
        for (j = 0; j < `RPX_N_ROUT; j = j + 1)
        begin : g_rout
            assign fields_nx[2*j +: 2] = tx_points[j] ? `RPX_PT_ON : `RPX_PT_OFF;
        end
    endgenerate
    // the rest of the 128-field payload is carried as zero
    assign fields_nx[`RPX_PAYLOAD_W-1:2*`RPX_N_ROUT] = {(`RPX_PAYLOAD_W-2*`RPX_N_ROUT){1'b0}};

    wire [15:0] int_nx  = int_cnt + 16'h1;
    wire        elapse  = ms_tick && (interval != 16'h0) && (int_nx >= interval);
    wire        chg     = (tx_points != pts_prev);
    wire        launch  = tx_pend && !tx_valid;
    wire        done    = tx_valid && tx_ready;
    wire [17:0] hold3   = {2'b00, interval} * `RPX_HOLD_MULT;

    // send scheduling; payload frozen while offered
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            tx_pend   <= 1'b1; // first message after reset
            tx_valid  <= 1'b0;
            int_cnt   <= 16'h0;
            pts_prev  <= {`RPX_N_ROUT{1'b0}};
            tx_ident  <= {ID_W{1'b0}};
            tx_hold   <= 18'h0;
            tx_fields <= {`RPX_PAYLOAD_W{1'b0}};
        end
        else
        begin
            pts_prev <= tx_points;
            // a change or an elapsed interval while one is pending is not lost
            tx_pend  <= chg || elapse || (tx_pend && !launch);
            if (done)
            begin
                tx_valid <= 1'b0;
                int_cnt  <= 16'h0;
            end
            else if (ms_tick)
            begin
                int_cnt <= int_nx;
            end
            if (launch)
            begin
                tx_valid  <= 1'b1;
                tx_ident  <= local_id;
                tx_hold   <= hold3;
                tx_fields <= fields_nx;
            end
        end
    end

endmodule

// ---- rpx_chk_assertions.sv ----
// concurrent checks on the point exchange ports
module rpx_chk (
    // clock and reset
    input wire logic         aclk,
    input wire logic         aresetn,
    // register bus answers
    input wire logic         arvalid,
    input wire logic         arready,
    input wire logic         rvalid,
    input wire logic         rready,
    input wire logic [31:0]  rdata,
    input wire logic         bvalid,
    input wire logic         bready,
    input wire logic [1:0]   bresp,
    // message sides
    input wire logic         rx_valid,
    input wire logic         rx_ready,
    input wire logic         tx_valid,
    input wire logic         tx_ready,
    input wire logic [255:0] tx_fields,
    input wire logic [15:0]  orig_online
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // -------------------------------------------
    // handshakes hold until taken; read answer one cycle after the request
    // -------------------------------------------
    bhold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write answer dropped early");
    rhold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read answer dropped early");
    rlat_a: assert property (arvalid && arready |=> rvalid)
        else $error("read answer late");
    txhold_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_fields))
        else $error("sent message withdrawn");
    // -------------------------------------------
    // message content and timing
    // -------------------------------------------
    txtop_a: assert property (tx_valid |-> tx_fields[255:128] == '0)
        else $error("unused fields not zero");
    power_a: assert property ($rose(aresetn) |-> ##[0:2] tx_valid)
        else $error("no message after reset");
    scan_a: assert property (rx_valid && rx_ready |=> !rx_ready [*8])
        else $error("message taken during scan");
    scanend_a: assert property (rx_valid && rx_ready |-> ##[32:34] rx_ready)
        else $error("originator scan too long");
    // an originator only comes online inside a scan, never on its own
    online_a: assert property (|(orig_online & ~$past(orig_online)) |->
        !$past(rx_ready) || !$past(rx_ready, 2))
        else $error("originator online without message");
    cover property (rx_valid && rx_ready);
    cover property (tx_valid && !tx_ready);
    cover property (|orig_online ##1 !(|orig_online));
endmodule
bind rpx_exchange rpx_chk u_chk (.*);

// ---- rpx_peer.sv ----
// peer relay model: offers messages to the block and takes the ones it sends
module rpx_peer (
    input  wire logic         aclk,
    input  wire logic         rx_ready,
    input  wire logic         tx_valid,
    output logic              rx_valid,
    output logic [31:0]       rx_ident,
    output logic [17:0]       rx_hold,
    output logic [255:0]      rx_fields,
    output logic              tx_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    logic slow = 1'b0;  // stall every other cycle
    initial
    begin
        rx_valid = 1'b0;
        rx_ident = 32'h0;
        rx_hold = 18'h0;
        rx_fields = 256'h0;
        tx_ready = 1'b0;
    end
    // sink for sent messages
    always @(posedge aclk)
        tx_ready <= slow ? !tx_ready : 1'b1;
    // offer one message until taken; released ident and fields show its inverse, hold a fixed pattern
    task send(input logic [31:0] id, input logic [15:0] ivl, input logic [255:0] f);
        rx_valid <= 1'b1;
        rx_ident <= id;
        rx_hold <= {2'b00, ivl} * 18'h3;
        rx_fields <= f;
        do @(posedge aclk); while (rx_ready !== 1'b1);
        rx_valid <= 1'b0;
        rx_ident <= ~id;
        rx_hold <= 18'h2aaaa;
        rx_fields <= ~f;
    endtask
endmodule

// ---- testbench.sv ----
// register-level test sequence for the point exchange block
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic         aclk = 1'b0, aresetn = 1'b0;
    logic         awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [7:0]   awaddr = 8'h00, araddr = 8'h00;
    logic [31:0]  wdata = 32'h0, d, rdata, rx_ident, tx_ident, rin_state;
    logic [3:0]   wstrb = 4'hf;
    logic [63:0]  tx_points = 64'h0;
    logic [1:0]   bresp, rresp, r;
    logic [17:0]  rx_hold, tx_hold;
    logic [255:0] rx_fields, tx_fields, f;
    logic [15:0]  orig_online;
    logic         awready, wready, bvalid, arready, rvalid, irq;
    logic         rx_valid, rx_ready, tx_valid, tx_ready;
    int           miscompares = 0, tests_run = 0;
    initial forever #12.5 aclk = ~aclk;
    // 4-cycle millisecond keeps hold timers short
    rpx_exchange #(.CYC_PER_MS(4)) uut (.*);
    rpx_peer peer (.*);
    task chk(input string n, input logic [31:0] s, input logic [31:0] e);
        tests_run++;
        if (s !== e)
        begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge aclk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin @(posedge aclk); if (awready) awvalid <= 1'b0; if (wready) wvalid <= 1'b0; end
        while (bvalid !== 1'b1);
        bready <= 1'b0;
        chk("bresp", bresp, 32'h0);
    endtask
    task rd(input logic [7:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin @(posedge aclk); if (arready) arvalid <= 1'b0; end while (rvalid !== 1'b1);
        rready <= 1'b0;
        d = rdata;
        r = rresp;
    endtask
    task wait_tx;
        do @(posedge aclk); while (tx_valid !== 1'b1);
    endtask
    task conclude;
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // watchdog: the sequence needs under 500 cycles
    initial
    begin
        repeat (3000) @(posedge aclk);
        miscompares++;
        conclude;
    end
    initial
    begin
        f = {128{2'b01}};
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        wait_tx;
        chk("hold", tx_hold, 32'h0bb8);
        chk("ident", tx_ident, 32'h5a01);
        rd(8'h00);
        chk("interval", d, 32'h3e8);
        wr(8'h00, 32'h2);
        repeat (20) @(posedge aclk);
        wait_tx;
        chk("hold", tx_hold, 32'h6);
        tx_points <= 64'h1;
        peer.slow <= 1'b1;
        repeat (12) @(posedge aclk);
        wait_tx;
        chk("fields_lo", tx_fields[31:0], 32'h5555_5556);
        chk("fields_63", tx_fields[127:96], 32'h5555_5555);
        // originator 1 feeds input 0 field 33 latest/off, 1 field 0 on, 2 field 0 latest/on
        wr(8'h40, 32'h1234);
        wr(8'h80, 32'h0003_2101);
        wr(8'h84, 32'h0000_0001);
        wr(8'h88, 32'h0002_0001);
        wr(8'h08, 32'h1);
        rd(8'h18);
        chk("rin", d, 32'hffff_fffe);
        peer.send(32'h9999, 16'd10, ~f);
        repeat (40) @(posedge aclk);
        rd(8'h0c);
        chk("online", d, 32'h0);
        peer.send(32'h1234, 16'd10, f ^ (256'h3 << 66) ^ 256'h3);
        repeat (40) @(posedge aclk);
        rd(8'h0c);
        chk("online", d, 32'h1);
        rd(8'h18);
        chk("rin", d, 32'hffff_ffff);
        peer.send(32'h1234, 16'd10, f ^ (256'h3 << 66));
        repeat (40) @(posedge aclk);
        rd(8'h18);
        chk("rin", d, 32'hffff_fff9);
        chk("rin_pins", rin_state, 32'hffff_fff9);
        repeat (150) @(posedge aclk);
        rd(8'h0c);
        chk("online", d, 32'h0);
        rd(8'h18);
        chk("rin", d, 32'hffff_fffb);
        wr(8'h14, 32'h4);
        chk("irq", irq, 32'h1);
        wr(8'h10, 32'h4);
        chk("irq", irq, 32'h0);
        rd(8'h3c);
        chk("rresp", r, 32'h2);
        conclude;
    end
endmodule
